// *** include/host_spi_pkg.sv ***
/*
  Constants for the host serial slave port: word framing, sampling
  figures and the link timing that the port relies on.
  Assumes a system clock of 200 MHz that is much faster than the host clock.
*/
package host_spi_pkg;
  // framing
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BIT_CNT_LAST = 4'hF;
  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // synchroniser depth and bundle width (clock, select, data, strap)
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_WIDTH = 4;
  // timing
  localparam int SYS_CLK_PERIOD_PS = 5000;
  localparam int HOST_CLK_MAX_KHZ = 25000;
  localparam int HOST_CLK_MIN_PERIOD_PS = 40000;
  localparam int HOST_CLK_MIN_PERIOD_CYC = HOST_CLK_MIN_PERIOD_PS / SYS_CLK_PERIOD_PS;
  localparam int I2C_CLK_MAX_KHZ = 400;
  localparam int CS_GAP_MIN_PS = 61000;
  localparam int CS_GAP_MIN_CYC = (CS_GAP_MIN_PS + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  // output level loaded by reset, held until the first reply word is loaded
  localparam logic SDO_IDLE = 1'b0;
  // port states
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_OFF} port_state_type;
endpackage : host_spi_pkg

// *** src/pin_sync.sv ***
/*
  Multi-bit two-stage synchroniser, one independent chain per bit.
  Assumes each bit is a level from outside the i_sys_clk domain and
  that reset is held for at least STAGES clocks so the chain is filled.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  input wire logic i_sys_clk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] chain [STAGES];

  // no reset: sampling goes on through reset, so a strap is seen and
  // no false pin edge shows at release; first stage feeds only the next
  always_ff @(posedge i_sys_clk) begin
    chain[0] <= i_async;
    for (int i = 1; i < STAGES; i++) begin
      chain[i] <= chain[i-1];
    end
  end

  assign o_sync = chain[STAGES-1];
endmodule : pin_sync

// *** src/host_spi_slave_port.sv ***
/*
  Host serial slave port: the host drives clock, active-low select and
  data in; the port assembles 16-bit words and shifts reply words out.
  Assumes host pins are asynchronous and the system clock is at least
  eight times the host clock; command interpretation sits outside.
*/
// Notes on behaviour
// [R1] a strap selects serial-slave or two-wire form; two-wire form here parks the port
// [R2] host clock up to 25 MHz serial, 400 kHz two-wire; host keeps to it
// [R3] a stopped host clock, high or low, loses no bits or state
// [R4] while selected, every 16 clock cycles one 16-bit word goes to the interpreter
// [R5] first output bit driven from select fall or clock fall, whichever is later
// [R6] host keeps select high at least 61 ns between transactions
// [R7] words may follow back to back with select held low throughout
// [R8] a select-low period not of 8 or whole 16-bit words resets the port
// [R9] host keeps select low over a whole command or chain of commands
// [R10] select rising ends the command sequence and resets the port logic
// [R11] host may sample replies on either clock edge, delaying the first clock
// [R12] data output released whenever select is high
// [R13] input sampled on clock rise, output launched on clock fall
`timescale 1ns/100ps
module host_spi_slave_port (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_host_clk,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_serial_in,
  input wire logic i_i2c_strap,
  input wire logic [15:0] i_tx_word,
  output logic o_host_serial_out,
  output logic o_host_serial_out_en,
  output logic [15:0] o_rx_word,
  output logic o_rx_valid,
  output logic o_rx_byte,
  output logic o_tx_taken,
  output logic o_frame_end,
  output logic o_frame_error,
  output logic o_i2c_selected
);
  logic [host_spi_pkg::SYNC_WIDTH-1:0] pins_sync;
  logic s_clk;
  logic s_cs_n;
  logic s_din;
  logic s_strap;
  logic clk_prev;
  logic cs_prev;
  host_spi_pkg::port_state_type state;
  logic [3:0] bit_cnt;
  logic word_seen;
  logic rise_seen;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic i2c_mode;

  // every host pin crosses two flops; 5 ns sampling resolves a 20 ns high phase [R2]
  pin_sync #(
    .WIDTH(host_spi_pkg::SYNC_WIDTH),
    .STAGES(host_spi_pkg::SYNC_STAGES)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_async({i_i2c_strap, i_host_serial_in, i_host_chip_select_n, i_host_clk}),
    .o_sync(pins_sync)
  );

  assign s_clk = pins_sync[0];
  assign s_cs_n = pins_sync[1];
  assign s_din = pins_sync[2];
  assign s_strap = pins_sync[3];

  // edge detection on synchronised copies only
  logic clk_rise;
  logic clk_fall;
  logic cs_fall;
  logic cs_rise;
  logic active;
  logic word_done;
  logic frame_ok;
  logic shift_out;
  logic load_next;
  assign clk_rise = s_clk && !clk_prev;
  assign clk_fall = !s_clk && clk_prev;
  assign cs_fall = !s_cs_n && cs_prev;
  assign cs_rise = s_cs_n && !cs_prev;
  assign active = (state == host_spi_pkg::ST_ACTIVE) && !s_cs_n;
  assign word_done = active && clk_rise && (bit_cnt == host_spi_pkg::BIT_CNT_LAST); // R4
  // good frame: whole words, or one lone byte [R8]
  assign frame_ok = ((bit_cnt == host_spi_pkg::BIT_CNT_RESET) && word_seen) ||
                    ((bit_cnt == host_spi_pkg::BIT_CNT_BYTE) && !word_seen);
  // a fall only shifts after a rise, so a fall before the first rise just re-drives bit 15 [R5]
  assign shift_out = active && clk_fall && rise_seen;
  assign load_next = shift_out && (bit_cnt == host_spi_pkg::BIT_CNT_RESET); // R7

  // edge history
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      clk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      clk_prev <= s_clk;
      cs_prev <= s_cs_n;
    end
  end

  // strap caught while reset is held, kept afterwards
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      i2c_mode <= s_strap; // R1
    end
  end

  // port state; select high returns ST_ACTIVE to idle, while two-wire form holds ST_OFF [R10]
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= host_spi_pkg::ST_IDLE;
    end else if (i2c_mode) begin
      state <= host_spi_pkg::ST_OFF; // R1
    end else begin
      case (state)
        host_spi_pkg::ST_IDLE: begin
          if (cs_fall) begin
            state <= host_spi_pkg::ST_ACTIVE;
          end
        end
        host_spi_pkg::ST_ACTIVE: begin
          if (s_cs_n) begin
            state <= host_spi_pkg::ST_IDLE; // R10
          end
        end
        default: begin
          state <= host_spi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // receive side: count and shift on rise; nothing moves without an edge [R3]
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !active) begin
      bit_cnt <= host_spi_pkg::BIT_CNT_RESET; // R10
      rx_shift <= host_spi_pkg::WORD_RESET;
      rise_seen <= 1'b0;
    end else if (clk_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      rx_shift <= {rx_shift[14:0], s_din}; // R13
      rise_seen <= 1'b1;
    end else if (clk_fall) begin
      rise_seen <= 1'b0;
    end
  end

  // word seen flag survives to the select rise that judges the frame
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || cs_fall) begin
      word_seen <= 1'b0;
    end else if (word_done) begin
      word_seen <= 1'b1; // R7
    end
  end

  // hand words to the interpreter; a lone byte is handed on the select rise
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rx_word <= host_spi_pkg::WORD_RESET;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 1'b0;
      o_frame_end <= 1'b0;
      o_frame_error <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_byte <= 1'b0;
      o_frame_end <= 1'b0;
      o_frame_error <= 1'b0;
      if (word_done) begin
        o_rx_word <= {rx_shift[14:0], s_din}; // R4
        o_rx_valid <= 1'b1;
      end else if (cs_rise && state == host_spi_pkg::ST_ACTIVE) begin
        o_frame_end <= frame_ok; // R10
        o_frame_error <= !frame_ok; // R8
        if (frame_ok && !word_seen) begin
          o_rx_word <= {8'h00, rx_shift[7:0]};
          o_rx_valid <= 1'b1;
          o_rx_byte <= 1'b1;
        end
      end
    end
  end

  // transmit side: load on select fall and after each full word, shift on fall
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_shift <= host_spi_pkg::WORD_RESET;
      o_host_serial_out <= host_spi_pkg::SDO_IDLE;
      o_tx_taken <= 1'b0;
    end else begin
      o_tx_taken <= 1'b0;
      if ((cs_fall && !i2c_mode) || load_next) begin
        tx_shift <= i_tx_word; // R5
        o_host_serial_out <= i_tx_word[15];
        o_tx_taken <= 1'b1;
      end else if (shift_out) begin
        tx_shift <= {tx_shift[14:0], 1'b0}; // R13
        o_host_serial_out <= tx_shift[14];
      end
    end
  end

  // output enable follows select; released in the cycle after select rises
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || s_cs_n || i2c_mode) begin
      o_host_serial_out_en <= 1'b0; // R12
    end else begin
      o_host_serial_out_en <= 1'b1;
    end
  end

  // mode flag for the outside world
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_i2c_selected <= 1'b0;
    end else begin
      o_i2c_selected <= i2c_mode;
    end
  end

  // checks
  property p_off_mode_silent;
    @(posedge i_sys_clk) disable iff (i_rst) i2c_mode |=> !o_host_serial_out_en && !o_rx_valid;
  endproperty
  a_off_mode_silent: assert property (p_off_mode_silent) else $error("port active in two-wire form"); // R1

  property p_word_out;
    @(posedge i_sys_clk) disable iff (i_rst)
      word_done |=> o_rx_valid && !o_rx_byte && o_rx_word[0] == $past(s_din);
  endproperty
  a_word_out: assert property (p_word_out) else $error("word not handed after 16 rises"); // R4

  property p_sel_rise_reset;
    @(posedge i_sys_clk) disable iff (i_rst)
      cs_rise |=> bit_cnt == host_spi_pkg::BIT_CNT_RESET && state != host_spi_pkg::ST_ACTIVE;
  endproperty
  a_sel_rise_reset: assert property (p_sel_rise_reset) else $error("select rise did not reset port"); // R10

  property p_release;
    @(posedge i_sys_clk) disable iff (i_rst) s_cs_n |=> !o_host_serial_out_en;
  endproperty
  a_release: assert property (p_release) else $error("output driven with select high"); // R12

  property p_bad_frame;
    @(posedge i_sys_clk) disable iff (i_rst)
      cs_rise && state == host_spi_pkg::ST_ACTIVE && !frame_ok |=> o_frame_error && !o_frame_end ##1 !o_frame_error;
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame length not flagged"); // R8

  property p_first_bit;
    @(posedge i_sys_clk) disable iff (i_rst)
      cs_fall && !i2c_mode |=> o_host_serial_out == $past(i_tx_word[15]) ##1 o_host_serial_out_en;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit not driven at select fall"); // R5

  property p_sample_rise;
    @(posedge i_sys_clk) disable iff (i_rst)
      active && clk_rise && !word_done |=> rx_shift[0] == $past(s_din) && bit_cnt == $past(bit_cnt) + 4'h1;
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("input not sampled on clock rise"); // R13

  property p_launch_fall;
    @(posedge i_sys_clk) disable iff (i_rst)
      shift_out && !load_next |=> o_host_serial_out == $past(tx_shift[14]);
  endproperty
  a_launch_fall: assert property (p_launch_fall) else $error("output not launched on clock fall"); // R13

  property p_static_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      active && !clk_rise && !clk_fall ##1 !s_cs_n |-> $stable(bit_cnt) && $stable(rx_shift);
  endproperty
  a_static_hold: assert property (p_static_hold) else $error("state lost with clock static"); // R3

  cover property (@(posedge i_sys_clk) disable iff (i_rst) o_rx_valid && !o_rx_byte ##[1:300] o_rx_valid); // R7
  cover property (@(posedge i_sys_clk) disable iff (i_rst) o_rx_byte);
  cover property (@(posedge i_sys_clk) disable iff (i_rst) o_frame_error);
  cover property (@(posedge i_sys_clk) disable iff (i_rst) load_next);
endmodule : host_spi_slave_port

// *** test/host_master_model.sv ***
/*
  Behavioural host that masters the serial port: clock idle low, data
  launched on clock fall, replies sampled on clock rise, msb first.
  Assumes the bench resolves the device's released data pin.
*/
`timescale 1ns/100ps
module host_master_model (
  output logic o_host_clk,
  output logic o_host_chip_select_n,
  output logic o_host_serial_in,
  input wire logic i_host_serial_out
);
  localparam real HALF_NS = 62.5;
  // offset keeps every pin edge clear of the system clock edges
  localparam real SKEW_NS = 1.3;

  // pins idle: select high, clock low
  initial begin
    o_host_clk = 1'h0;
    o_host_chip_select_n = 1'h1;
    o_host_serial_in = 1'h0;
  end

  // one frame; a stall holds the clock high mid-frame to test retention
  task automatic xfer(input int nbits, input logic [31:0] mosi, input int pause_ns, output logic [31:0] miso);
    miso = 32'h0000_0000;
    #SKEW_NS;
    o_host_chip_select_n = 1'h0;
    for (int i = nbits - 1; i >= 0; i--) begin
      o_host_serial_in = mosi[i];
      #HALF_NS;
      o_host_clk = 1'h1;
      miso = {miso[30:0], i_host_serial_out};
      if (i == nbits / 2) #(pause_ns);
      #HALF_NS;
      o_host_clk = 1'h0;
    end
    #HALF_NS;
    o_host_chip_select_n = 1'h1;
    #100;
  endtask : xfer
endmodule : host_master_model

// *** test/host_spi_slave_port_tb.sv ***
/*
  Self-checking bench for the host serial slave port: a table of frames
  through the host model, then strap parking and a fresh reset.
  Assumes the host model masters the link with a 125 ns clock.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module host_spi_slave_port_tb;
  typedef struct {int nb; logic [31:0] mo; logic [15:0] t1; logic [15:0] t2; int ps;} row_type;
  localparam int NROWS = 6;
  // frame length, host data, reply words, clock stall in ns
  row_type rows [NROWS] = '{
    '{16, 32'h0000_A5C3, 16'h3C5A, 16'h0000, 0},
    '{8, 32'h0000_0096, 16'hB2E1, 16'h0000, 0},
    '{12, 32'h0000_0F0F, 16'h8001, 16'h0000, 0},
    '{32, 32'hDEAD_BEEF, 16'h1357, 16'hC0DE, 0},
    '{20, 32'h000A_BCDE, 16'h7E81, 16'h4BB4, 0},
    '{16, 32'h0000_6C39, 16'hF00F, 16'h0000, 3000}};
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic strap = 1'h0;
  logic last_sdo = 1'h0;
  logic [15:0] tx_word = 16'h0000;
  logic host_clk, cs_n, sdi, sdo, sdo_en, rx_valid, rx_byte, tx_taken, frame_end, frame_error, i2c_sel;
  logic [15:0] rx_word;
  wire logic sdo_w;
  logic [16:0] rxq [$];
  int n_errors = 0;
  int samples_checked = 0;
  int n_end = 0;
  int n_fe = 0;
  int n_tk = 0;

  always #2.5 sys_clk = ~sys_clk;

  // released pin has no pull: the host sees the inverse of the last level
  always @(posedge sys_clk) if (sdo_en) last_sdo <= sdo;
  assign sdo_w = sdo_en ? sdo : ~last_sdo;

  host_spi_slave_port dut_u (.i_sys_clk(sys_clk), .i_rst(rst), .i_host_clk(host_clk),
    .i_host_chip_select_n(cs_n), .i_host_serial_in(sdi), .i_i2c_strap(strap), .i_tx_word(tx_word),
    .o_host_serial_out(sdo), .o_host_serial_out_en(sdo_en), .o_rx_word(rx_word), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .o_tx_taken(tx_taken), .o_frame_end(frame_end), .o_frame_error(frame_error),
    .o_i2c_selected(i2c_sel));
  host_master_model host_u (.o_host_clk(host_clk), .o_host_chip_select_n(cs_n), .o_host_serial_in(sdi),
    .i_host_serial_out(sdo_w));

  // collect words handed to the interpreter and how frames close
  always @(negedge sys_clk) begin
    if (rx_valid === 1'h1) rxq.push_back({rx_byte, rx_word});
    if (frame_end === 1'h1) n_end++;
    if (frame_error === 1'h1) n_fe++;
    if (tx_taken === 1'h1) n_tk++;
  end

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // one frame; the second reply word is swapped in after the first load
  task automatic run(input row_type r);
    logic [31:0] mi;
    logic [16:0] ex;
    int e0, f0, t0, k, bad;
    rxq.delete();
    e0 = n_end;
    t0 = n_tk;
    f0 = n_fe;
    bad = (r.nb != 8 && r.nb % 16 != 0);
    @(negedge sys_clk) tx_word = r.t1;
    fork
      host_u.xfer(r.nb, r.mo, r.ps, mi);
      begin
        #500;
        @(negedge sys_clk) tx_word = r.t2;
      end
    join
    for (k = 0; k < 40 && n_end + n_fe == e0 + f0; k++) @(posedge sys_clk);
    if (k == 40) begin
      n_errors++;
      give_verdict();
    end
    @(negedge sys_clk);
    `CHK(mi, {r.t1, r.t2} >> (32 - r.nb))
    `CHK(n_fe - f0, bad)
    `CHK(n_end - e0, 1 - bad)
    `CHK(sdo_en, 1'h0)
    `CHK(n_tk - t0, 1 + r.nb / 16)
    `CHK(rxq.size(), (r.nb == 8) ? 1 : r.nb / 16)
    for (k = 0; k < rxq.size(); k++) begin
      ex = (r.nb == 8) ? {9'h100, r.mo[7:0]} : {1'h0, 16'(r.mo >> (r.nb - 16 * (k + 1)))};
      `CHK(rxq[k], ex)
    end
  endtask : run

  // main sequence: reset, table, then hand-written cases
  initial begin
    logic [31:0] mi;
    int e0;
    repeat (5) @(negedge sys_clk);
    `CHK({sdo_en, rx_valid, frame_end, frame_error, i2c_sel}, 5'h00)
    rst = 1'h0;
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < NROWS; i++) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    // strap high parks the port: host traffic must leave no trace
    strap = 1'h1;
    rst = 1'h1;
    repeat (5) @(negedge sys_clk);
    rst = 1'h0;
    rxq.delete();
    e0 = n_end + n_fe + n_tk;
    host_u.xfer(16, 32'h0000_5AA5, 0, mi);
    `CHK(i2c_sel, 1'h1)
    `CHK(rxq.size() + n_end + n_fe + n_tk - e0, 0)
    $display("strap test done");
    // strap is only taken in reset, so a new reset restores the port
    strap = 1'h0;
    rst = 1'h1;
    repeat (5) @(negedge sys_clk);
    rst = 1'h0;
    repeat (2) @(negedge sys_clk);
    `CHK(i2c_sel, 1'h0)
    run(rows[3]);
    $display("reset test done");
    give_verdict();
  end
endmodule : host_spi_slave_port_tb
